// File: include/rbra_map.svh
// Register offsets, field positions, reset values and pin indices of the remote read arbiter.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef RBRA_MAP_SVH
`define RBRA_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RBRA_REG_CTRL      3'h0
`define RBRA_REG_WCFG      3'h1
`define RBRA_REG_STAT      3'h2
`define RBRA_REG_PCL       3'h3
`define RBRA_REG_PCH       3'h4

// ****************************************************************
// Field positions
// ****************************************************************
`define RBRA_CTRL_MS_LSB   0
`define RBRA_CTRL_LOR_BIT  2
`define RBRA_WCFG_IW_LSB   0
`define RBRA_WCFG_DW_LSB   2
`define RBRA_STAT_RR_BIT   0
`define RBRA_STAT_HIB_BIT  1
`define RBRA_STAT_OWN_BIT  2

// ****************************************************************
// Memory select codes
// ****************************************************************
`define RBRA_MS_DATA_MEMORY       2'h0
`define RBRA_MS_INSTRUCTION_MEMORY       2'h1
`define RBRA_MS_PCL        2'h2
`define RBRA_MS_PCH        2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define RBRA_MS_RST        2'h0
`define RBRA_IW_RST        2'h0
`define RBRA_DW_RST        3'h0
`define RBRA_PC_RST        16'h0000
// Pin order into the synchroniser: select, read_n, wait_n, cmd
`define RBRA_PIN_RST       4'h6
`define RBRA_PIN_SEL       0
`define RBRA_PIN_RDN       1
`define RBRA_PIN_WAITN     2
`define RBRA_PIN_CMD       3

`endif

// File: include/rbra_pkg.sv
// Types of the remote read arbiter.
// Assumes nothing beyond the compile order given.
package rbra_pkg;

	// ****************************************************************
	// Arbiter states
	// ****************************************************************
	typedef enum logic [8:0]
	{
		ST_IDLE     = 9'h001,
		ST_HELD     = 9'h002,
		ST_RELEASE  = 9'h004,
		ST_SETUP    = 9'h008,
		ST_ACCESS   = 9'h010,
		ST_VALID    = 9'h020,
		ST_FINISH   = 9'h040,
		ST_DFINISH  = 9'h080,
		ST_RETURN   = 9'h100
	} rbra_state_t;

	// ****************************************************************
	// Access targets
	// ****************************************************************
	typedef enum logic [2:0]
	{
		TGT_RIC  = 3'h0,
		TGT_PCL  = 3'h1,
		TGT_PCH  = 3'h2,
		TGT_DATA_MEMORY = 3'h3,
		TGT_IL   = 3'h4,
		TGT_IH   = 3'h5
	} rbra_target_t;

endpackage

// File: include/rbra_wait_if.sv
// Link between the arbiter and its wait state counter.
// Assumes both ends run on the arbiter clock.
`timescale 1ns/1ns
interface rbra_wait_if #(parameter int CNT_W = 3);
	logic             load;
	logic             dec;
	logic [CNT_W-1:0] load_val;
	logic             done;

	modport ctrl (output load, output dec, output load_val, input done);
	modport counter (input load, input dec, input load_val, output done);
endinterface

// File: src/rbra_arbiter.sv
// Remote access arbiter, buffered read mode: shares the local buses with a remote processor.
// Assumes a remote processor on buffered buses and a local timing control unit on CLK_IN.
//
// Functional notes
// RL1 - A remote read stays in progress until the remote read strobe is removed.
// RL2 - Without select and read strobe together, stay idle and start nothing.
// RL3 - Read under lockout, local request or local grant goes to held-off and stays there while any of them lasts.
// RL4 - In idle and held-off, grant local requests when lock is high and buses free.
// RL5 - Drop acknowledge as soon as the remote read condition is seen.
// RL6 - Free lockout and no local request: enter bus release; grant nothing until idle.
// RL7 - Float the address bus, and the data bus for data memory, after release.
// RL8 - Setup state raises ownership, keeps acknowledge low, loads the wait counter with the target's wait count.
// RL9 - Command high reads the control register, already shown on the data bus.
// RL10 - Memory select 10 or 11 presents the program counter low or high byte.
// RL11 - Data memory: assert read strobe, float both buses, loop for data waits.
// RL12 - Instruction memory: low byte then high byte by the high-byte flag.
// RL13 - Clear the high-byte flag on reset and on writing 01 to memory select.
// RL14 - Wait input low extends the access for as long as it stays low.
// RL15 - After waits, enter data valid, raise acknowledge, loop while the read stands.
// RL16 - Ownership falls after the read ends, except in the data memory finish state.
// RL17 - Non data memory: finish state with ownership low, then idle.
// RL18 - Data memory: finish with ownership high, then return with ownership low.
// RL19 - After an instruction read toggle the flag; high byte increments the counter.
// RL20 - Delay bus takeover one cycle and stall the timing unit meanwhile.
// RL21 - Data memory: one settle cycle, acknowledge after one plus the data waits.
// RL22 - Remote ends with strobe high; device releases read strobe, ownership later.
// RL23 - While lockout is set every new remote access keeps acknowledge low.
// RL24 - All state changes happen on the rising clock edge. Reset to idle is asynchronous on RESET_IN.
// RL25 - Sticky remote read flag sets when a data memory read enters data valid; write one clears.
// RL26 - Select and read strobe are synchronised before any decision.
`timescale 1ns/1ns
`include "rbra_map.svh"
module rbra_arbiter #(
	parameter int IW_W  = 2,
	parameter int DW_W  = 3,
	parameter int PC_W  = 16
) (
	input  wire logic        CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        REMOTE_SELECT_IN,
	input  wire logic        REMOTE_READ_STROBE_N_IN,
	input  wire logic        CMD_IN,
	input  wire logic        WAIT_N_IN,
	input  wire logic        LOCK_IN,
	input  wire logic        LOCAL_BUS_REQUEST_IN,
	input  wire logic [15:0] INSTRUCTION_MEMORY_DATA_IN,
	input  wire logic [2:0]  REG_ADDR_IN,
	input  wire logic [7:0]  REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [7:0]  REG_RDATA_OUT,
	output logic             REMOTE_ACKNOWLEDGE_OUT,
	output logic             REMOTE_BUS_OWNERSHIP_OUT,
	output logic             MEM_READ_N_OUT,
	output logic             LOCAL_BUS_GRANT_OUT,
	output logic             REMOTE_WAIT_CYCLE_OUT,
	output logic             ADDR_OE_OUT,
	output logic             AD_OE_OUT,
	output logic      [7:0]  AD_OUT
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0]               pins_raw;
	logic [3:0]               pins_sync;
	logic                     rd_cond;
	logic                     wait_n;
	logic                     cmd;
	rbra_pkg::rbra_state_t    state_q;
	rbra_pkg::rbra_state_t    state_d;
	rbra_pkg::rbra_target_t   tgt_q;
	rbra_pkg::rbra_target_t   tgt_d;
	logic [1:0]               ms_q;
	logic                     lockout_q;
	logic [IW_W-1:0]          iw_q;
	logic [DW_W-1:0]          dw_q;
	logic                     hib_q;
	logic                     rr_flag_q;
	logic [PC_W-1:0]          pc_q;
	logic                     busy_local;
	logic                     grant_d;
	logic                     wr_ctrl;
	logic                     instruction_memory_done;
	logic                     a_float_d;
	logic [7:0]               ric_byte;
	logic [7:0]               ad_d;

	rbra_wait_if #(.CNT_W(DW_W)) wif ();

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic rbra_pkg::rbra_target_t tgt_of(input logic c, input logic [1:0] ms, input logic high_byte_flag);
		if (c)
			return rbra_pkg::TGT_RIC;
		case (ms)
			`RBRA_MS_PCL:  return rbra_pkg::TGT_PCL;
			`RBRA_MS_PCH:  return rbra_pkg::TGT_PCH;
			`RBRA_MS_DATA_MEMORY: return rbra_pkg::TGT_DATA_MEMORY;
			default:       return high_byte_flag ? rbra_pkg::TGT_IH : rbra_pkg::TGT_IL;
		endcase
	endfunction

	function automatic logic is_arb_free(input rbra_pkg::rbra_state_t s);
		return (s == rbra_pkg::ST_IDLE) || (s == rbra_pkg::ST_HELD);
	endfunction

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	assign pins_raw = {CMD_IN, WAIT_N_IN, REMOTE_READ_STROBE_N_IN, REMOTE_SELECT_IN};

	rbra_sync #(
		.WIDTH     (4),
		.RESET_VAL (`RBRA_PIN_RST)
	) u_sync (
		.clk_in   (CLK_IN),
		.reset_in (RESET_IN),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	// Select and strobe act only as one combined condition
	assign rd_cond  = pins_sync[`RBRA_PIN_SEL] & ~pins_sync[`RBRA_PIN_RDN]; // RL26
	assign wait_n   = pins_sync[`RBRA_PIN_WAITN];
	assign cmd      = pins_sync[`RBRA_PIN_CMD];
	assign ric_byte = {5'h00, lockout_q, ms_q};
	assign wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == `RBRA_REG_CTRL);
	assign busy_local = lockout_q || LOCAL_BUS_GRANT_OUT || LOCAL_BUS_REQUEST_IN;
	assign instruction_memory_done = (state_q == rbra_pkg::ST_FINISH)
		&& ((tgt_q == rbra_pkg::TGT_IL) || (tgt_q == rbra_pkg::TGT_IH));

	// ****************************************************************
	// Wait state counter
	// ****************************************************************
	always_comb
	begin
		wif.load = (state_q == rbra_pkg::ST_SETUP); // RL8
		if (tgt_q == rbra_pkg::TGT_DATA_MEMORY)
			wif.load_val = dw_q;
		else if ((tgt_q == rbra_pkg::TGT_IL) || (tgt_q == rbra_pkg::TGT_IH))
			wif.load_val = DW_W'(iw_q);
		else
			wif.load_val = '0;
		wif.dec = (state_q == rbra_pkg::ST_ACCESS);
	end

	rbra_wait_ctr #(
		.CNT_W (DW_W)
	) u_wait_ctr (
		.clk_in    (CLK_IN),
		.reset_in  (RESET_IN),
		.wait_port (wif.counter)
	);

	// ****************************************************************
	// Arbiter state machine
	// ****************************************************************
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			rbra_pkg::ST_IDLE, rbra_pkg::ST_HELD, rbra_pkg::ST_RETURN:
			begin
				if (!rd_cond)
					state_d = rbra_pkg::ST_IDLE; // RL2
				else if (busy_local)
					state_d = rbra_pkg::ST_HELD; // RL3 RL23
				else
					state_d = rbra_pkg::ST_RELEASE; // RL6 RL20
			end
			rbra_pkg::ST_RELEASE:
				state_d = rbra_pkg::ST_SETUP; // RL8
			rbra_pkg::ST_SETUP:
				state_d = rbra_pkg::ST_ACCESS; // RL9 RL10 RL11 RL12
			rbra_pkg::ST_ACCESS:
			begin
				if (wif.done && wait_n)
					state_d = rbra_pkg::ST_VALID; // RL14 RL15 RL21
			end
			rbra_pkg::ST_VALID:
			begin
				if (!rd_cond)
					state_d = (tgt_q == rbra_pkg::TGT_DATA_MEMORY) ? rbra_pkg::ST_DFINISH : rbra_pkg::ST_FINISH; // RL1
			end
			rbra_pkg::ST_FINISH:
				state_d = rbra_pkg::ST_IDLE; // RL17
			rbra_pkg::ST_DFINISH:
				state_d = rbra_pkg::ST_RETURN; // RL18
			default:
				state_d = rbra_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			state_q <= rbra_pkg::ST_IDLE;
		else
			state_q <= state_d; // RL24
	end

	// Target is fixed when the buses are taken
	always_comb
	begin
		if ((state_d == rbra_pkg::ST_RELEASE) && (state_q != rbra_pkg::ST_RELEASE))
			tgt_d = tgt_of(cmd, ms_q, hib_q);
		else
			tgt_d = tgt_q;
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			tgt_q <= rbra_pkg::TGT_RIC;
		else
			tgt_q <= tgt_d;
	end

	// ****************************************************************
	// Bus and handshake outputs
	// ****************************************************************
	assign grant_d = LOCAL_BUS_REQUEST_IN && LOCK_IN && is_arb_free(state_d); // RL4 RL6
	assign a_float_d = !is_arb_free(state_d) && (state_d != rbra_pkg::ST_IDLE);

	always_comb
	begin
		ad_d = ric_byte; // RL9
		if ((state_d == rbra_pkg::ST_ACCESS) || (state_d == rbra_pkg::ST_VALID))
		begin
			case (tgt_d)
				rbra_pkg::TGT_PCL: ad_d = pc_q[7:0]; // RL10
				rbra_pkg::TGT_PCH: ad_d = pc_q[15:8]; // RL10
				rbra_pkg::TGT_IL:  ad_d = INSTRUCTION_MEMORY_DATA_IN[7:0]; // RL12
				rbra_pkg::TGT_IH:  ad_d = INSTRUCTION_MEMORY_DATA_IN[15:8]; // RL12
				default:           ad_d = ric_byte;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			REMOTE_ACKNOWLEDGE_OUT   <= 1'b1;
			REMOTE_BUS_OWNERSHIP_OUT <= 1'b0;
			MEM_READ_N_OUT           <= 1'b1;
			ADDR_OE_OUT              <= 1'b1;
			AD_OE_OUT                <= 1'b1;
			AD_OUT                   <= 8'h00;
		end
		else
		begin
			REMOTE_ACKNOWLEDGE_OUT   <= !(state_d inside {rbra_pkg::ST_HELD, rbra_pkg::ST_RELEASE,
				rbra_pkg::ST_SETUP, rbra_pkg::ST_ACCESS}); // RL5 RL15 RL23
			REMOTE_BUS_OWNERSHIP_OUT <= state_d inside {rbra_pkg::ST_SETUP, rbra_pkg::ST_ACCESS,
				rbra_pkg::ST_VALID, rbra_pkg::ST_DFINISH}; // RL8 RL16 RL17 RL18 RL22
			MEM_READ_N_OUT           <= !((state_d inside {rbra_pkg::ST_ACCESS, rbra_pkg::ST_VALID})
				&& (tgt_d == rbra_pkg::TGT_DATA_MEMORY)); // RL11 RL21 RL22
			ADDR_OE_OUT              <= !a_float_d; // RL7
			AD_OE_OUT                <= !(a_float_d && (tgt_d == rbra_pkg::TGT_DATA_MEMORY)); // RL7 RL11
			AD_OUT                   <= ad_d;
		end
	end

	// Local side: grant only while the arbiter is free, else stall the timing unit
	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			LOCAL_BUS_GRANT_OUT   <= 1'b0;
			REMOTE_WAIT_CYCLE_OUT <= 1'b0;
		end
		else
		begin
			LOCAL_BUS_GRANT_OUT   <= grant_d; // RL4
			REMOTE_WAIT_CYCLE_OUT <= LOCAL_BUS_REQUEST_IN && !grant_d; // RL20
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			ms_q      <= `RBRA_MS_RST;
			lockout_q <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			ms_q      <= REG_WDATA_IN[`RBRA_CTRL_MS_LSB +: 2];
			lockout_q <= REG_WDATA_IN[`RBRA_CTRL_LOR_BIT];
		end
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			iw_q <= `RBRA_IW_RST;
			dw_q <= `RBRA_DW_RST;
		end
		else if (REG_WR_IN && (REG_ADDR_IN == `RBRA_REG_WCFG))
		begin
			iw_q <= REG_WDATA_IN[`RBRA_WCFG_IW_LSB +: IW_W];
			dw_q <= REG_WDATA_IN[`RBRA_WCFG_DW_LSB +: DW_W];
		end
	end

	// Writing the instruction memory code realigns the word boundary
	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			hib_q <= 1'b0; // RL13
		else if (wr_ctrl && (REG_WDATA_IN[`RBRA_CTRL_MS_LSB +: 2] == `RBRA_MS_INSTRUCTION_MEMORY))
			hib_q <= 1'b0; // RL13
		else if (instruction_memory_done)
			hib_q <= !hib_q; // RL19
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			pc_q <= `RBRA_PC_RST;
		else if (REG_WR_IN && (REG_ADDR_IN == `RBRA_REG_PCL))
			pc_q[7:0] <= REG_WDATA_IN;
		else if (REG_WR_IN && (REG_ADDR_IN == `RBRA_REG_PCH))
			pc_q[15:8] <= REG_WDATA_IN;
		else if (instruction_memory_done && (tgt_q == rbra_pkg::TGT_IH))
			pc_q <= pc_q + PC_W'(1); // RL19
	end

	// Sticky flag: the set wins over a clear in the same cycle
	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			rr_flag_q <= 1'b0;
		else if ((state_q == rbra_pkg::ST_ACCESS) && (state_d == rbra_pkg::ST_VALID)
			&& (tgt_q == rbra_pkg::TGT_DATA_MEMORY))
			rr_flag_q <= 1'b1; // RL25
		else if (REG_WR_IN && (REG_ADDR_IN == `RBRA_REG_STAT) && REG_WDATA_IN[`RBRA_STAT_RR_BIT])
			rr_flag_q <= 1'b0; // RL25
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			REG_RDATA_OUT <= 8'h00;
		else if (REG_RD_IN)
		begin
			case (REG_ADDR_IN)
				`RBRA_REG_CTRL: REG_RDATA_OUT <= ric_byte;
				`RBRA_REG_WCFG: REG_RDATA_OUT <= {3'h0, dw_q, iw_q};
				`RBRA_REG_STAT: REG_RDATA_OUT <= {5'h00, REMOTE_BUS_OWNERSHIP_OUT, hib_q, rr_flag_q};
				`RBRA_REG_PCL:  REG_RDATA_OUT <= pc_q[7:0];
				`RBRA_REG_PCH:  REG_RDATA_OUT <= pc_q[15:8];
				default:        REG_RDATA_OUT <= 8'h00;
			endcase
		end
		else
			REG_RDATA_OUT <= 8'h00;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RESET_IN);

	property p_idle_stay;
		state_q == rbra_pkg::ST_IDLE && !rd_cond |=> state_q == rbra_pkg::ST_IDLE;
	endproperty
	a_idle_stay: assert property (p_idle_stay) else $error("Arbiter left idle without a read"); // RL2

	property p_lockout_hold;
		is_arb_free(state_q) && rd_cond && lockout_q |=> state_q == rbra_pkg::ST_HELD && !REMOTE_ACKNOWLEDGE_OUT;
	endproperty
	a_lockout_hold: assert property (p_lockout_hold) else $error("Lockout did not hold off the read"); // RL3

	property p_take_bus;
		state_q == rbra_pkg::ST_IDLE && rd_cond && !busy_local
		|=> state_q == rbra_pkg::ST_RELEASE && !ADDR_OE_OUT ##1 state_q == rbra_pkg::ST_SETUP
		&& REMOTE_BUS_OWNERSHIP_OUT && !REMOTE_ACKNOWLEDGE_OUT ##1 state_q == rbra_pkg::ST_ACCESS;
	endproperty
	a_take_bus: assert property (p_take_bus) else $error("Bus takeover sequence broken"); // RL6

	property p_ack_low;
		state_q inside {rbra_pkg::ST_HELD, rbra_pkg::ST_RELEASE, rbra_pkg::ST_SETUP, rbra_pkg::ST_ACCESS}
		|-> !REMOTE_ACKNOWLEDGE_OUT;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("Acknowledge high during arbitration"); // RL5

	property p_data_memory_access;
		state_q == rbra_pkg::ST_ACCESS && tgt_q == rbra_pkg::TGT_DATA_MEMORY
		|-> !MEM_READ_N_OUT && !ADDR_OE_OUT && !AD_OE_OUT;
	endproperty
	a_data_memory_access: assert property (p_data_memory_access) else $error("Data memory access outputs wrong"); // RL11

	property p_wait_extend;
		state_q == rbra_pkg::ST_ACCESS && !wait_n |=> state_q == rbra_pkg::ST_ACCESS;
	endproperty
	a_wait_extend: assert property (p_wait_extend) else $error("Wait input did not extend access"); // RL14

	property p_valid_hold;
		state_q == rbra_pkg::ST_VALID && rd_cond |=> state_q == rbra_pkg::ST_VALID && REMOTE_ACKNOWLEDGE_OUT;
	endproperty
	a_valid_hold: assert property (p_valid_hold) else $error("Read ended before the strobe was removed"); // RL1

	property p_data_memory_end;
		state_q == rbra_pkg::ST_VALID && tgt_q == rbra_pkg::TGT_DATA_MEMORY && !rd_cond
		|=> MEM_READ_N_OUT && REMOTE_BUS_OWNERSHIP_OUT ##1 state_q == rbra_pkg::ST_RETURN
		&& !REMOTE_BUS_OWNERSHIP_OUT && !AD_OE_OUT;
	endproperty
	a_data_memory_end: assert property (p_data_memory_end) else $error("Data memory termination order wrong"); // RL22

	property p_other_end;
		state_q == rbra_pkg::ST_VALID && tgt_q != rbra_pkg::TGT_DATA_MEMORY && !rd_cond
		|=> state_q == rbra_pkg::ST_FINISH && !REMOTE_BUS_OWNERSHIP_OUT ##1 state_q == rbra_pkg::ST_IDLE;
	endproperty
	a_other_end: assert property (p_other_end) else $error("Finish sequence wrong"); // RL17

	property p_pc_inc;
		instruction_memory_done && tgt_q == rbra_pkg::TGT_IH && !REG_WR_IN |=> pc_q == $past(pc_q) + PC_W'(1) && !hib_q;
	endproperty
	a_pc_inc: assert property (p_pc_inc) else $error("Counter not advanced after high byte"); // RL19

	property p_rr_set;
		state_q == rbra_pkg::ST_ACCESS && state_d == rbra_pkg::ST_VALID && tgt_q == rbra_pkg::TGT_DATA_MEMORY
		|=> rr_flag_q;
	endproperty
	a_rr_set: assert property (p_rr_set) else $error("Remote read flag not set"); // RL25

	property p_no_grant;
		!is_arb_free(state_q) |-> !LOCAL_BUS_GRANT_OUT;
	endproperty
	a_no_grant: assert property (p_no_grant) else $error("Local grant during remote access"); // RL6

	c_data_memory_read: cover property (state_q == rbra_pkg::ST_DFINISH ##1 state_q == rbra_pkg::ST_RETURN);
	c_instruction_memory_high: cover property (instruction_memory_done && tgt_q == rbra_pkg::TGT_IH);
	c_held_off:  cover property (state_q == rbra_pkg::ST_HELD ##1 state_q == rbra_pkg::ST_RELEASE);
	c_wait_ext:  cover property (state_q == rbra_pkg::ST_ACCESS && wif.done && !wait_n);

endmodule

// File: src/rbra_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ns
module rbra_sync #(
	parameter int               WIDTH     = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk_in or posedge reset_in)
			begin
				if (reset_in)
				begin
					s1_q[i]     <= RESET_VAL[i];
					s2_q[i]     <= RESET_VAL[i];
					s3_q[i]     <= RESET_VAL[i];
					sync_out[i] <= RESET_VAL[i];
				end
				else
				begin
					s1_q[i] <= async_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					// A change counts once stages two and three agree
					if (s2_q[i] == s3_q[i])
						sync_out[i] <= s3_q[i];
				end
			end
		end
	endgenerate

endmodule

// File: src/rbra_wait_ctr.sv
// Programmed wait state counter for remote accesses.
// Assumes load and dec never arrive together.
`timescale 1ns/1ns
module rbra_wait_ctr #(
	parameter int CNT_W = 3
) (
	input  wire logic   clk_in,
	input  wire logic   reset_in,
	rbra_wait_if.counter wait_port
);

	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			cnt_q <= '0;
		else if (wait_port.load)
			cnt_q <= wait_port.load_val;
		else if (wait_port.dec && cnt_q != '0)
			cnt_q <= cnt_q - CNT_W'(1);
	end

	assign wait_port.done = (cnt_q == '0);

endmodule

// File: testbench/rbra_host.sv
// Remote host model: buffered read on select and read strobe.
// Assumes go_in is one cycle wide and the ack line idles high.
`timescale 1ns/1ns
module rbra_host (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic       ack_in,
	input  wire logic [7:0] ad_in,
	output logic            sel_out,
	output logic            rd_n_out,
	output logic [7:0]      data_out,
	output logic            done_out
);
	initial
	begin
		sel_out = 1'b0;
		rd_n_out = 1'b1;
		data_out = 8'h00;
		done_out = 1'b0;
		forever
		begin
			@(posedge clk_in);
			if (go_in === 1'b1)
			begin
				sel_out <= 1'b1;
				rd_n_out <= 1'b0;
				@(posedge clk_in);
				while (ack_in !== 1'b0)
					@(posedge clk_in);
				while (ack_in !== 1'b1)
					@(posedge clk_in);
				data_out <= ad_in;
				sel_out <= 1'b0;
				rd_n_out <= 1'b1;
				done_out <= 1'b1;
				@(posedge clk_in);
				done_out <= 1'b0;
			end
		end
	end
endmodule

// File: testbench/tb.sv
// Self-checking bench of the remote read arbiter.
// Assumes rbra_host drives select and read strobe; the bench drives command, wait, lock and request.
`timescale 1ns/1ns
`include "rbra_map.svh"
module tb;
	logic       clk, ack, own, mem_rd_n, gnt, wcy, aoe, doe, sel, rd_n, hdone;
	logic       rst = 1'b1, cmd = 1'b0, req = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, wn = 1'b1, lk = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wd = 8'h00, rdat, ad, hd;
	logic [7:0] ctl_t [3] = '{8'h02, 8'h03, 8'h03};
	logic [7:0] exp_t [3] = '{8'h34, 8'h12, 8'h03};
	int         bad_count = 0, n_tests = 0, cyc = 0, n;

	rbra_arbiter u_dut (.CLK_IN(clk), .RESET_IN(rst), .REMOTE_SELECT_IN(sel),
		.REMOTE_READ_STROBE_N_IN(rd_n), .CMD_IN(cmd), .WAIT_N_IN(wn), .LOCK_IN(lk),
		.LOCAL_BUS_REQUEST_IN(req), .INSTRUCTION_MEMORY_DATA_IN(16'hbeef), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
		.REMOTE_ACKNOWLEDGE_OUT(ack), .REMOTE_BUS_OWNERSHIP_OUT(own), .MEM_READ_N_OUT(mem_rd_n),
		.LOCAL_BUS_GRANT_OUT(gnt), .REMOTE_WAIT_CYCLE_OUT(wcy), .ADDR_OE_OUT(aoe),
		.AD_OE_OUT(doe), .AD_OUT(ad));
	rbra_host u_host (.clk_in(clk), .go_in(go), .ack_in(ack), .ad_in(ad), .sel_out(sel),
		.rd_n_out(rd_n), .data_out(hd), .done_out(hdone));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(nm, e, rdat);
	endtask
	task automatic start;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic finish;
		@(posedge clk);
		while (hdone !== 1'b1)
			@(posedge clk);
		repeat (8) @(posedge clk);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cut a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done;
		end
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("ack", 8'h01, {7'h0, ack});
		chk("own", 8'h00, {7'h0, own});
		rdc("stat", `RBRA_REG_STAT, 8'h00);
		rdc("unmapped", 3'h7, 8'h00);
		$display("test reset done");
		wrr(`RBRA_REG_PCL, 8'h34);
		wrr(`RBRA_REG_PCH, 8'h12);
		for (int i = 0; i < 3; i++)
		begin
			cmd <= (i == 2);
			wrr(`RBRA_REG_CTRL, ctl_t[i]);
			start;
			finish;
			chk("ad byte", exp_t[i], hd);
		end
		cmd <= 1'b0;
		wrr(`RBRA_REG_CTRL, 8'h01);
		start;
		finish;
		chk("instruction_memory low", 8'hef, hd);
		rdc("stat", `RBRA_REG_STAT, 8'h02);
		start;
		finish;
		chk("instruction_memory high", 8'hbe, hd);
		rdc("pc low", `RBRA_REG_PCL, 8'h35);
		start;
		finish;
		wrr(`RBRA_REG_CTRL, 8'h01);
		rdc("stat", `RBRA_REG_STAT, 8'h00);
		$display("test byte reads done");
		// Data memory read, two data waits, local request during access
		wrr(`RBRA_REG_WCFG, 8'h08);
		wrr(`RBRA_REG_CTRL, 8'h00);
		start;
		n = 0;
		while (own !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		req <= 1'b1;
		n = 0;
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		chk("ack delay", 8'h04, n[7:0]);
		chk("read_n", 8'h00, {7'h0, mem_rd_n});
		chk("bus oe", 8'h00, {6'h0, aoe, doe});
		chk("gnt wcy", 8'h01, {6'h0, gnt, wcy});
		req <= 1'b0;
		finish;
		chk("own end", 8'h00, {7'h0, own});
		rdc("stat", `RBRA_REG_STAT, 8'h01);
		wrr(`RBRA_REG_STAT, 8'h01);
		rdc("stat", `RBRA_REG_STAT, 8'h00);
		$display("test data read done");
		wn <= 1'b0;
		wrr(`RBRA_REG_CTRL, 8'h04);
		start;
		repeat (10) @(posedge clk);
		req <= 1'b1;
		repeat (2) @(posedge clk);
		chk("gnt", 8'h01, {7'h0, gnt});
		chk("ack", 8'h00, {7'h0, ack});
		chk("own", 8'h00, {7'h0, own});
		lk <= 1'b0;
		repeat (2) @(posedge clk);
		chk("gnt wcy nolock", 8'h01, {6'h0, gnt, wcy});
		req <= 1'b0;
		lk <= 1'b1;
		repeat (2) @(posedge clk);
		wrr(`RBRA_REG_CTRL, 8'h00);
		n = 0;
		while (own !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		repeat (8) @(posedge clk);
		chk("wait own ack", 8'h02, {6'h0, own, ack});
		wn <= 1'b1;
		finish;
		rdc("stat", `RBRA_REG_STAT, 8'h01);
		$display("test lockout done");
		test_done;
	end
endmodule
